/* File: bench/maint_far_model.sv */
// Far-side model: configuration storage engine and card file engine.
`timescale 1ns/10ps
module maint_far_model
  import maint_cmd_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire cfg_req_type cfg_req,
  input  wire logic        card_valid,
  output logic             store_busy,
  output logic             card_done,
  output logic             card_ok
);
  logic [3:0] store_q;  // Store cycles still to run.
  logic [3:0] card_q;   // Card cycles still to run.
  //////////////////////////////////////////////////////////////////
  // A store keeps the engine busy for eight cycles, long enough to see the pause.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_q <= 4'h0;
      card_q <= 4'h0;
    end else begin
      store_q <= cfg_req.store ? 4'h8 : store_q - {3'h0, |store_q};
      card_q <= card_valid ? 4'h6 : card_q - {3'h0, |card_q};
    end
  end
  assign store_busy = |store_q;
  assign card_done = card_q == 4'h1;
  assign card_ok = card_done;  // Every card operation succeeds.
endmodule

/* File: bench/maintenance_command_handler_test.sv */
// Testbench of the maintenance command handler.
`timescale 1ns/10ps
module maintenance_command_handler_test;
  import maint_cmd_pkg::*;
  logic         aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic         arvalid = 1'b0, rready = 1'b0, query_done = 1'b0, cfg_read_req = 1'b0;
  logic [7:0]   awaddr = 8'h00, araddr = 8'h00, query_code = 8'h00, replay_code, last_code;
  logic [31:0]  wdata = 32'h0000_0000, rdata, v;
  logic [3:0]   wstrb = 4'hF;
  logic [1:0]   bresp, rresp, r, last_op, br;
  logic         awready, wready, bvalid, arready, rvalid, replay_valid, store_busy, loop_suspend;
  logic         cfg_read_ok, cfg_read_minus, restart, link_mute, bind_active, bind_plus;
  logic         card_valid, card_done, card_ok;
  cfg_req_type  cfg_req;
  card_req_type card_req;
  int fail_count = 0, checks = 0, n_ld = 0, n_st = 0, n_df = 0, n_rp = 0, n_rs = 0, n_mi = 0, n_pl = 0, n_su = 0;
  int n_ok = 0;
  always #5 aclk = ~aclk;
  maint_cmd_handler #(.MS_CYCLES(4)) maint_cmd_handler_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .query_done, .query_code, .replay_valid, .replay_code, .cfg_req,
    .store_busy, .loop_suspend, .cfg_read_req, .cfg_read_ok, .cfg_read_minus, .restart, .link_mute,
    .bind_active, .bind_plus, .card_valid, .card_req, .card_done, .card_ok);
  maint_far_model maint_far_model_inst (.aclk, .aresetn, .cfg_req, .card_valid, .store_busy,
    .card_done, .card_ok);
  //////////////////////////////////////////////////////////////////
  // Pulses are counted on the falling edge, clear of the rising edges at which tasks drive and read.
  always @(negedge aclk) begin
    if (cfg_req.load === 1'b1) n_ld++;
    if (cfg_req.store === 1'b1) n_st++;
    if (cfg_req.dflt === 1'b1) n_df++;
    if (restart === 1'b1) n_rs++;
    if (cfg_read_minus === 1'b1) n_mi++;
    if (cfg_read_ok === 1'b1) n_ok++;
    if (bind_plus === 1'b1) n_pl++;
    if (loop_suspend === 1'b1) n_su++;
    if (card_valid === 1'b1) last_op = card_req.op;
    if (replay_valid === 1'b1) begin
      n_rp++;
      last_code = replay_code;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask
  // Write: address and data go out together and each drops once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ka, kw, kb;
    kb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!kb) begin
      @(negedge aclk);
      ka = awvalid & awready;
      kw = wvalid & wready;
      kb = bvalid;
      br = bresp;
      @(posedge aclk);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ka, kr;
    kr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!kr) begin
      @(negedge aclk);
      ka = arvalid & arready;
      kr = rvalid;
      v = rdata;
      r = rresp;
      @(posedge aclk);
      if (ka) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [31:0] arg);
    wr(ARG_OFS, arg);
    wr(CMD_OFS, {28'h000_0000, op});
    repeat (3) @(posedge aclk);
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask
  task automatic t_lock;
    cmd(read_lock_cmd, 32'h0000_0000);
    rd(STATUS_OFS);
    chk({v[ST_REJECT], v[ST_LOCKED]}, 2'b10);
    cmd(read_lock_cmd, 32'h0000_0005);
    cfg_read_req <= 1'b1;
    @(posedge aclk);
    cfg_read_req <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(n_mi, 1);
    cmd(store_config_cmd, 32'h0000_0000);
    repeat (10) @(posedge aclk);
    chk({n_st, n_su > 0}, 2'b11);
    cmd(read_unlock_cmd, 32'h0000_0006);
    rd(STATUS_OFS);
    chk(v[ST_LOCKED], 1);
    cmd(read_unlock_cmd, 32'h0000_0005);
    rd(STATUS_OFS);
    chk(v[ST_LOCKED], 0);
    cfg_read_req <= 1'b1;
    @(posedge aclk);
    cfg_read_req <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(n_ok, 1);
  endtask
  task automatic t_keys;
    cmd(factory_restore_cmd, 32'h0000_0001);
    chk(n_df, 0);
    cmd(factory_restore_cmd, SAFETY_KEY);
    chk(n_df, 1);
    cmd(load_stored_config_cmd, 32'h0000_0000);
    chk(n_ld, 2);
    cmd(restart_cmd, SAFETY_KEY);
    chk(n_rs, 1);
    rst;
    chk(n_ld, 3);
    rd(8'h20);
    chk(r, RESP_DECERR);
    wr(8'h20, 32'h0000_0001);
    chk(br, RESP_DECERR);
  endtask
  task automatic t_hist;
    int c;
    for (int i = 0; i < 17; i++) begin
      query_done <= 1'b1;
      query_code <= 8'h10 + 8'(i);
      @(posedge aclk);
    end
    query_done <= 1'b0;
    cmd(hist_next_cmd, 32'h0000_0000);
    rd(STATUS_OFS);
    chk({last_code, 3'h0, v[12:8]}, 16'h1110);
    cmd(hist_auto_cmd, 32'h0000_7D01);
    rd(STATUS_OFS);
    chk(v[ST_AUTO], 0);
    cmd(hist_auto_cmd, 32'h0000_0002);
    c = n_rp;
    repeat (40) @(posedge aclk);
    chk(n_rp - c, 5);
    cmd(hist_next_cmd, 32'h0000_0000);
    c = n_rp;
    repeat (40) @(posedge aclk);
    chk(n_rp - c, 0);
    cmd(hist_clear_cmd, 32'h0000_0000);
    rd(STATUS_OFS);
    chk(v[12:8], 0);
  endtask
  task automatic t_misc;
    for (int k = 13; k < 16; k++) begin
      cmd(k[3:0], 32'h0000_0007);
      repeat (10) @(posedge aclk);
      chk(last_op, k[1:0]);
    end
    rd(STATUS_OFS);
    chk(v[ST_PLUS], 1);
    cmd(set_seconds_cmd, 32'h0000_0064);
    rd(SECONDS_OFS);
    chk(v, 32'h0000_0064);
    repeat (4000) @(posedge aclk);
    rd(SECONDS_OFS);
    chk(v, 32'h0000_0065);
    cmd(bind_cmd, 32'h0000_0000);
    repeat (7990) @(posedge aclk);
    chk(bind_active, 1);
    chk(n_pl, 0);
    repeat (20) @(posedge aclk);
    chk(bind_active, 0);
    chk(n_pl, 1);
    cmd(firmware_update_entry_cmd, 32'h0000_0001);
    chk(link_mute, 0);
    cmd(firmware_update_entry_cmd, SAFETY_KEY);
    chk(link_mute, 1);
    cmd(read_lock_cmd, 32'h0000_0005);
    rd(STATUS_OFS);
    chk({v[ST_DFU], v[ST_LOCKED]}, 2'b10);
  endtask
  task automatic stop_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    rst;
    chk(n_ld, 1);
    t_lock;
    t_keys;
    t_hist;
    t_misc;
    stop_test;
  end
  // The whole run needs about 12500 cycles; the watchdog allows three times that.
  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    stop_test;
  end
endmodule

/* File: core/maint_cmd_handler.sv */
// Maintenance command handler: AXI4-Lite command registers, history replay, lock, storage and card control.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module maint_cmd_handler
  import maint_cmd_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF  // Clock cycles per millisecond.
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [7:0]   awaddr,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  input  wire logic [7:0]   araddr,
  input  wire logic         arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  input  wire logic         query_done,
  input  wire logic [7:0]   query_code,
  output logic              replay_valid,
  output logic [7:0]        replay_code,
  output cfg_req_type       cfg_req,
  input  wire logic         store_busy,
  output logic              loop_suspend,
  input  wire logic         cfg_read_req,
  output logic              cfg_read_ok,
  output logic              cfg_read_minus,
  output logic              restart,
  output logic              link_mute,
  output logic              bind_active,
  output logic              bind_plus,
  output logic              card_valid,
  output card_req_type      card_req,
  input  wire logic         card_done,
  input  wire logic         card_ok
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  // The millisecond prescaler needs at least one cycle per tick.
  if (MS_CYCLES < 1) begin : g_bad_ms
    $error("MS_CYCLES must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Merges new bytes into an old word under the bus byte strobes.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

  // True when an offset names a register of this block.
  function automatic logic is_mapped(input logic [7:0] ofs);
    return (ofs == CMD_OFS) || (ofs == ARG_OFS) || (ofs == STATUS_OFS) ||
           (ofs == SECONDS_OFS) || (ofs == INTERVAL_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic [7:0]  awaddr_q;        // Captured write address.
  logic [31:0] wdata_q;         // Captured write data.
  logic [3:0]  wstrb_q;         // Captured write strobes.
  logic [31:0] arg_q;           // Command argument or key.
  logic [3:0]  last_op_q;       // Last opcode written, read back.
  logic [31:0] key_q;           // Secret key; zero while unlocked.
  logic        locked_q;        // Configuration reads blocked.
  logic        dfu_q;           // Update entry taken; link silenced.
  logic        reject_q;        // Last command written was refused.
  logic        boot_q;          // Power-on reload still to be issued.
  logic [7:0]  hist_q [HIST_DEPTH];  // Query history ring.
  logic [3:0]  hist_wr_q;       // Next history write slot.
  logic [4:0]  hist_cnt_q;      // Entries held, up to sixteen.
  logic [3:0]  hist_rd_q;       // Replay offset from the oldest entry.
  logic        auto_q;          // Automatic replay running.
  logic [14:0] interval_q;      // Replay interval in ms.
  logic [14:0] auto_ms_q;       // Milliseconds since last replay.
  logic [31:0] ms_cnt_q;        // Millisecond prescaler.
  logic [9:0]  sec_ms_q;        // Milliseconds within the second.
  logic [31:0] seconds_q;       // Seconds since the reference date.
  logic [11:0] bind_ms_q;       // Time left in the replug window.
  logic        card_busy_q;     // Card operation outstanding.
  logic        plus_q;          // Last card delete succeeded.

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  // A command executes when both halves of a write to the command register meet.
  wire         wr_commit  = !awready && !wready && !bvalid;
  wire         wr_mapped  = is_mapped(awaddr_q);
  wire         cmd_write  = wr_commit && (awaddr_q == CMD_OFS);
  wire         arg_write  = wr_commit && (awaddr_q == ARG_OFS);
  wire cmd_type op        = cmd_type'(wdata_q[3:0]);
  // No command from the link is obeyed once update entry was taken.
  wire         cmd_fire   = cmd_write && !dfu_q;
  wire         key_ok     = (arg_q == SAFETY_KEY);
  wire         ms_tick    = (ms_cnt_q == 32'(MS_CYCLES - 1));
  wire         sec_tick   = ms_tick && (sec_ms_q == 10'(SEC_MS - 1));
  wire         interval_ok = (arg_q >= 32'(AUTO_MIN_MS)) && (arg_q <= 32'(AUTO_MAX_MS));
  wire         auto_due   = auto_q && ms_tick && (auto_ms_q + 15'd1 >= interval_q);
  wire         fire_next  = cmd_fire && (op == hist_next_cmd);
  wire         do_replay  = (fire_next || auto_due) && (hist_cnt_q != 5'd0);
  wire [3:0]   hist_old   = hist_wr_q - hist_cnt_q[3:0];
  wire [3:0]   rd_slot    = hist_old + hist_rd_q;
  wire         keyed_cmd  = (op == factory_restore_cmd) || (op == restart_cmd) ||
                            (op == firmware_update_entry_cmd);
  wire         lock_ok    = !locked_q && (arg_q != KEY_RST);
  wire         unlock_ok  = locked_q && (arg_q == key_q);
  wire         refuse     = cmd_fire && ((keyed_cmd && !key_ok) ||
                            ((op == read_lock_cmd) && !lock_ok) ||
                            ((op == read_unlock_cmd) && !unlock_ok) ||
                            ((op == hist_auto_cmd) && !interval_ok));
  wire         ok_fire    = cmd_fire && !refuse;
  wire [31:0]  status_w   = {19'h0_0000, hist_cnt_q, loop_suspend, plus_q, card_busy_q,
                             bind_active, reject_q, dfu_q, auto_q, locked_q};
  wire [31:0]  rd_mux     = (araddr == CMD_OFS)      ? {28'h000_0000, last_op_q} :
                            (araddr == ARG_OFS)      ? arg_q :
                            (araddr == STATUS_OFS)   ? status_w :
                            (araddr == SECONDS_OFS)  ? seconds_q :
                            (araddr == INTERVAL_OFS) ? {17'h0_0000, interval_q} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data are taken in either order.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awaddr_q <= awaddr;
        awready  <= 1'b0;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready  <= 1'b0;
      end
      // Unmapped offsets get a decode error; the write is dropped.
      if (wr_commit) begin
        bvalid <= 1'b1;
        bresp  <= wr_mapped ? RESP_OKAY : RESP_DECERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Read channel: one cycle from address to data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_mux;
      rresp   <= is_mapped(araddr) ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Argument, lock, update entry and keyed commands.

  // Only opcodes that pass their checks change state; a refused one only sets the reject flag and the last opcode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arg_q     <= ARG_RST;
      last_op_q <= 4'h0;
      key_q     <= KEY_RST;
      locked_q  <= 1'b0;
      dfu_q     <= 1'b0;
      reject_q  <= 1'b0;
      restart   <= 1'b0;
      link_mute <= 1'b0;
    end else begin
      restart   <= 1'b0;
      link_mute <= dfu_q;
      if (arg_write) begin
        arg_q <= merge_bytes(arg_q, wdata_q, wstrb_q);
      end
      if (cmd_fire) begin
        last_op_q <= op;
        reject_q  <= refuse;
      end
      if (ok_fire) begin
        unique case (op)
          read_lock_cmd: begin
            key_q    <= arg_q;
            locked_q <= 1'b1;
          end
          read_unlock_cmd: begin
            key_q    <= KEY_RST;
            locked_q <= 1'b0;
          end
          firmware_update_entry_cmd: dfu_q <= 1'b1;
          restart_cmd: restart <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration storage requests and read gating.

  // The reload after reset stands in for power-on; the stored copy wins over unsaved edits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_q         <= 1'b1;
      cfg_req        <= '0;
      loop_suspend   <= 1'b0;
      cfg_read_ok    <= 1'b0;
      cfg_read_minus <= 1'b0;
    end else begin
      boot_q        <= 1'b0;
      cfg_req.load  <= boot_q || (ok_fire && (op == load_stored_config_cmd));
      // Storing stays allowed while locked.
      cfg_req.store <= ok_fire && (op == store_config_cmd);
      cfg_req.dflt  <= ok_fire && (op == factory_restore_cmd);
      // The loop pauses the cycle after the request, then follows the engine's busy one cycle late.
      loop_suspend  <= store_busy || (ok_fire && (op == store_config_cmd));
      cfg_read_ok    <= cfg_read_req && !locked_q;
      cfg_read_minus <= cfg_read_req && locked_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Query history ring and replay.

  // The ring is kept without reset; the count says which slots hold data.
  always_ff @(posedge aclk) begin
    if (query_done) begin
      hist_q[hist_wr_q] <= query_code;
    end
  end

  // A full ring overwrites its oldest slot, which drops that entry.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist_wr_q    <= 4'h0;
      hist_cnt_q   <= 5'd0;
      hist_rd_q    <= 4'h0;
      auto_q       <= 1'b0;
      interval_q   <= 15'd0;
      auto_ms_q    <= 15'd0;
      replay_valid <= 1'b0;
      replay_code  <= 8'h00;
    end else begin
      replay_valid <= do_replay;
      if (do_replay) begin
        replay_code <= hist_q[rd_slot];
        hist_rd_q   <= (5'(hist_rd_q) + 5'd1 >= hist_cnt_q) ? 4'h0 : hist_rd_q + 4'h1;
      end
      if (query_done) begin
        hist_wr_q <= hist_wr_q + 4'h1;
        if (hist_cnt_q != 5'(HIST_DEPTH)) begin
          hist_cnt_q <= hist_cnt_q + 5'd1;
        end
      end
      if (auto_q && ms_tick) begin
        auto_ms_q <= auto_due ? 15'd0 : auto_ms_q + 15'd1;
      end
      // A bare advance or a clear ends automatic sending.
      if (ok_fire && ((op == hist_next_cmd) || (op == hist_clear_cmd))) begin
        auto_q <= 1'b0;
      end
      if (ok_fire && (op == hist_clear_cmd)) begin
        hist_cnt_q <= 5'd0;
        hist_rd_q  <= 4'h0;
      end
      if (ok_fire && (op == hist_auto_cmd)) begin
        auto_q     <= 1'b1;
        interval_q <= arg_q[14:0];
        auto_ms_q  <= 15'd0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base, seconds counter and bind window.

  // The millisecond tick also drives the bind window and the replay timer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_q    <= 32'h0000_0000;
      sec_ms_q    <= 10'd0;
      seconds_q   <= SEC_RST;
      bind_ms_q   <= 12'd0;
      bind_active <= 1'b0;
      bind_plus   <= 1'b0;
    end else begin
      ms_cnt_q  <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
      bind_plus <= 1'b0;
      if (ms_tick) begin
        sec_ms_q <= sec_tick ? 10'd0 : sec_ms_q + 10'd1;
      end
      if (ok_fire && (op == set_seconds_cmd)) begin
        seconds_q <= arg_q;
        sec_ms_q  <= 10'd0;
      end else if (sec_tick) begin
        seconds_q <= seconds_q + 32'h0000_0001;
      end
      // The receiver power line is held in bind mode for the replug window.
      if (ok_fire && (op == bind_cmd)) begin
        bind_active <= 1'b1;
        bind_ms_q   <= 12'(BIND_MS - 1);
      end else if (bind_active && ms_tick) begin
        if (bind_ms_q == 12'd0) begin
          bind_active <= 1'b0;
          bind_plus   <= 1'b1;
        end else begin
          bind_ms_q <= bind_ms_q - 12'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Card requests.

  // A new card command while one is outstanding is dropped, not queued.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      card_valid  <= 1'b0;
      card_req    <= '0;
      card_busy_q <= 1'b0;
      plus_q      <= 1'b0;
    end else begin
      card_valid <= 1'b0;
      if (ok_fire && !card_busy_q && (op == card_list_cmd || op == card_dump_cmd || op == card_delete_cmd)) begin
        card_valid    <= 1'b1;
        card_busy_q   <= 1'b1;
        card_req.name <= arg_q;
        card_req.op   <= (op == card_list_cmd) ? CARD_LIST :
                         (op == card_dump_cmd) ? CARD_DUMP : CARD_DEL;
        plus_q        <= 1'b0;
      end else if (card_done && card_busy_q) begin
        card_busy_q <= 1'b0;
        plus_q      <= card_ok && (card_req.op == CARD_DEL);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_lock_zero_key: assert property (cmd_fire && op == read_lock_cmd && arg_q == 32'h0000_0000 |=>
    locked_q == $past(locked_q)) else $error("Zero key changed lock");
  chk_lock_takes_key: assert property (cmd_fire && op == read_lock_cmd && !locked_q && arg_q != 32'h0000_0000
    |=> locked_q && key_q == $past(arg_q)) else $error("Lock not taken");
  chk_unlock_match: assert property (cmd_fire && op == read_unlock_cmd && locked_q && arg_q == key_q
    |=> !locked_q) else $error("Matching key did not unlock");
  chk_bad_key_kept: assert property (cmd_fire && op == read_unlock_cmd && arg_q != key_q
    |=> locked_q == $past(locked_q) && reject_q) else $error("Wrong key changed lock");
  chk_read_minus: assert property (cfg_read_req && locked_q |=> cfg_read_minus && !cfg_read_ok)
    else $error("Locked read not answered by minus");
  chk_restart_key: assert property ($rose(restart) |-> $past(cmd_fire && op == restart_cmd && key_ok))
    else $error("Restart without key");
  chk_dfu_silent: assert property (dfu_q && cmd_write |=> $stable(locked_q) && !cfg_req.store)
    else $error("Command obeyed after update entry");
  chk_suspend_store: assert property (store_busy |=> loop_suspend)
    else $error("Loop not suspended during store");
  chk_hist_cap: assert property (query_done && hist_cnt_q == 5'd16 && !(ok_fire && op == hist_clear_cmd)
    |=> hist_cnt_q == 5'd16) else $error("Full history did not hold sixteen");
  chk_advance_stops: assert property (fire_next |=> !auto_q)
    else $error("Advance did not stop replay");
  chk_restore_key: assert property (cfg_req.dflt |-> $past(cmd_fire && op == factory_restore_cmd && key_ok))
    else $error("Defaults without key");

  cov_auto_replay: cover property (auto_q && replay_valid ##[2:1000] (auto_q && replay_valid));
  cov_lock_cycle: cover property (locked_q ##1 cfg_read_minus ##[1:20] !locked_q);
  cov_bind_plus: cover property ($fell(bind_active) && bind_plus);

endmodule

/* File: include/maint_cmd_pkg.sv */
// Package: constants, register map and carrier types of the maintenance command handler.
package maint_cmd_pkg;

  // Clock and timing.
  localparam int CLK_PERIOD_NS   = 10;         // 100 MHz system clock.
  localparam int MS_NS           = 1_000_000;  // One millisecond in ns.
  localparam int MS_CYCLES_DEF   = MS_NS / CLK_PERIOD_NS;
  localparam int SEC_MS          = 1000;       // Milliseconds per second.
  localparam int BIND_MS         = 2000;       // Receiver replug window in ms.
  localparam int AUTO_MIN_MS     = 1;          // Shortest replay interval in ms.
  localparam int AUTO_MAX_MS     = 32000;      // Longest replay interval in ms.
  localparam int HIST_DEPTH      = 16;         // Query history entries.

  // Fixed safety key 321654987 for keyed commands.
  localparam logic [31:0] SAFETY_KEY = 32'h132C_10CB;

  // Register byte offsets.
  localparam logic [7:0] CMD_OFS      = 8'h00;
  localparam logic [7:0] ARG_OFS      = 8'h04;
  localparam logic [7:0] STATUS_OFS   = 8'h08;
  localparam logic [7:0] SECONDS_OFS  = 8'h0C;
  localparam logic [7:0] INTERVAL_OFS = 8'h10;

  // Status field positions.
  localparam int ST_LOCKED   = 0;
  localparam int ST_AUTO     = 1;
  localparam int ST_DFU      = 2;
  localparam int ST_REJECT   = 3;
  localparam int ST_BIND     = 4;
  localparam int ST_CARD     = 5;
  localparam int ST_PLUS     = 6;
  localparam int ST_SUSPEND  = 7;
  localparam int ST_HCNT_LSB = 8;

  // Reset values.
  localparam logic [31:0] ARG_RST  = 32'h0000_0000;
  localparam logic [31:0] KEY_RST  = 32'h0000_0000;  // Zero means unlocked.
  localparam logic [31:0] SEC_RST  = 32'h0000_0000;

  // Bus response codes.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // Command opcodes written to the command register.
  typedef enum logic [3:0] {
    hist_next_cmd             = 4'b0001,
    hist_clear_cmd            = 4'b0010,
    hist_auto_cmd             = 4'b0011,
    bind_cmd                  = 4'b0100,
    firmware_update_entry_cmd = 4'b0101,
    load_stored_config_cmd    = 4'b0110,
    factory_restore_cmd       = 4'b0111,
    store_config_cmd          = 4'b1000,
    read_lock_cmd             = 4'b1001,
    read_unlock_cmd           = 4'b1010,
    restart_cmd               = 4'b1011,
    set_seconds_cmd           = 4'b1100,
    card_list_cmd             = 4'b1101,
    card_dump_cmd             = 4'b1110,
    card_delete_cmd           = 4'b1111
  } cmd_type;

  // Card operation codes.
  localparam logic [1:0] CARD_LIST = 2'b01;
  localparam logic [1:0] CARD_DUMP = 2'b10;
  localparam logic [1:0] CARD_DEL  = 2'b11;

  // Requests to the configuration storage engine.
  typedef struct packed {
    logic load;   // Stored copy into working memory.
    logic store;  // Working memory into stored copy.
    logic dflt;   // Factory values into both.
  } cfg_req_type;

  // Request to the card file engine.
  typedef struct packed {
    logic [1:0]  op;    // List, dump or delete.
    logic [31:0] name;  // File handle taken from the argument.
  } card_req_type;

endpackage
